/* File: rtl/eis_pkg.sv */
// constants, field layout and bus states of the external request enable and sense block
package eis_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int          NUM_PINS    = 12;
  localparam int          ADDR_W      = 6;
  localparam int          DATA_W      = 32;
  localparam int          REG_W       = 16;
  localparam int          SENSE_W     = 2 * NUM_PINS;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [5:0]  OFS_ENABLE  = 6'h00;
  localparam logic [5:0]  OFS_SENSE_H = 6'h04;
  localparam logic [5:0]  OFS_SENSE_L = 6'h08;
  localparam logic [5:0]  OFS_FLAGS   = 6'h0c;

  // ****************************************
  // implemented bits and reset values
  // ****************************************
  localparam logic [15:0] MASK_ENABLE  = 16'h0fff;
  localparam logic [15:0] MASK_SENSE_H = 16'h00ff;
  localparam logic [15:0] MASK_SENSE_L = 16'hffff;
  localparam logic [15:0] MASK_FLAGS   = 16'h0fff;
  localparam logic [15:0] RST_ENABLE   = 16'h0000;
  localparam logic [15:0] RST_SENSE    = 16'h0000;
  localparam logic [11:0] RST_FLAGS    = 12'h000;
  localparam logic [11:0] RST_PIN_IDLE = 12'hfff;

  // ****************************************
  // sense field: rise bit above fall bit
  // ****************************************
  localparam int          POS_SENSE_RISE = 1;
  localparam int          POS_SENSE_FALL = 0;
  localparam logic [1:0]  SENSE_LOW      = 2'h0;
  localparam logic [1:0]  SENSE_FALL     = 2'h1;
  localparam logic [1:0]  SENSE_RISE     = 2'h2;
  localparam logic [1:0]  SENSE_BOTH     = 2'h3;

  // ****************************************
  // bus slave states, value doubles as waitrequest
  // ****************************************
  typedef enum logic [0:0]
  {
    EIS_BUS_ACK  = 1'b0,
    EIS_BUS_WAIT = 1'b1
  } eis_bus_e;

endpackage : eis_pkg

/* File: rtl/eis_pin_sync.sv */
// two-flop synchroniser for the external request pins
`timescale 1ns/1ps
module eis_pin_sync
(
  input  wire logic                         clk_in,
  input  wire logic                         reset_in,
  input  wire logic [eis_pkg::NUM_PINS-1:0] async_in,
  output logic      [eis_pkg::NUM_PINS-1:0] sync_out
);

  import eis_pkg::*;

  logic [NUM_PINS-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      stage1   <= RST_PIN_IDLE;
      sync_out <= RST_PIN_IDLE;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : eis_pin_sync

/* File: rtl/eis_sense.sv */
// per-pin level and edge detection selected by the sense fields
`timescale 1ns/1ps
module eis_sense
(
  input  wire logic                         clk_in,
  input  wire logic                         reset_in,
  input  wire logic [eis_pkg::NUM_PINS-1:0] level_in,
  input  wire logic [eis_pkg::SENSE_W-1:0]  sense_in,
  output logic      [eis_pkg::NUM_PINS-1:0] hit_out
);

  import eis_pkg::*;

  logic [NUM_PINS-1:0] prev_level;

  // previous sampled level, idle high so reset makes no edge
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      prev_level <= RST_PIN_IDLE;
    else
      prev_level <= level_in;
  end

  // edge modes compare successive samples so each transition counts once, low mode follows the current level
  always_comb
  begin
    hit_out = '0;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      case (sense_in[2*i +: 2])
        SENSE_LOW:  hit_out[i] = ~level_in[i];
        SENSE_FALL: hit_out[i] = prev_level[i] & ~level_in[i];
        SENSE_RISE: hit_out[i] = ~prev_level[i] & level_in[i];
        SENSE_BOTH: hit_out[i] = prev_level[i] ^ level_in[i];
        default:    hit_out[i] = 1'b0;
      endcase
    end
  end

endmodule : eis_sense

/* File: rtl/eis_top.sv */
// external request enable, sense selection and request flags behind an Avalon-MM slave
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module eis_top
  import eis_pkg::*;
(
  input  wire logic                              clk_in,
  input  wire logic                              reset_in,
  input  wire logic [eis_pkg::ADDR_W-1:0]        avs_address_in,
  input  wire logic                              avs_read_in,
  input  wire logic                              avs_write_in,
  input  wire logic [eis_pkg::DATA_W-1:0]        avs_writedata_in,
  input  wire logic [3:0]                        avs_byteenable_in,
  output logic      [eis_pkg::DATA_W-1:0]        avs_readdata_out,
  output logic                                   avs_waitrequest_out,
  input  wire logic [eis_pkg::NUM_PINS-1:0]      ext_request_pin_n_in,
  output logic      [eis_pkg::NUM_PINS-1:0]      irq_request_out,
  output logic      [eis_pkg::NUM_PINS-1:0]      request_flag_out
);

  import eis_pkg::*;

  // ****************************************
  // helper functions
  // ****************************************

  // merge write data into a 16-bit register under the low byte enables
  function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                          input logic [15:0] wr_val,
                                          input logic [1:0]  be,
                                          input logic [15:0] keep);
    logic [15:0] lane;
    lane    = {{8{be[1]}}, {8{be[0]}}};
    merge16 = ((wr_val & lane) | (old_val & ~lane)) & keep;
  endfunction : merge16

  // one bit per pin whose sense field equals the given code
  function automatic logic [NUM_PINS-1:0] mode_mask(input logic [SENSE_W-1:0] sense,
                                                    input logic [1:0]         code);
    logic [NUM_PINS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_PINS; i++)
      m[i] = (sense[2*i +: 2] == code);
    mode_mask = m;
  endfunction : mode_mask

  // one bit per pin whose sense field differs between two settings
  function automatic logic [NUM_PINS-1:0] field_change(input logic [SENSE_W-1:0] a,
                                                       input logic [SENSE_W-1:0] b);
    logic [NUM_PINS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_PINS; i++)
      m[i] = (a[2*i +: 2] != b[2*i +: 2]);
    field_change = m;
  endfunction : field_change

  // ****************************************
  // state
  // ****************************************
  eis_bus_e              bus_state;
  eis_bus_e              next_bus_state;
  logic [15:0]           irq_enable_reg;
  logic [15:0]           sense_control_high;
  logic [15:0]           sense_control_low;
  logic [NUM_PINS-1:0]   request_flag_reg;
  logic [NUM_PINS-1:0]   pin_sync;
  logic [NUM_PINS-1:0]   sense_hit;

  // ****************************************
  // address decode and write strobes
  // ****************************************
  wire                   bus_req      = avs_read_in | avs_write_in;
  wire                   bus_take     = bus_req & (bus_state == EIS_BUS_WAIT);
  wire                   wr_commit    = avs_write_in & (bus_state == EIS_BUS_ACK);
  wire                   sel_enable   = (avs_address_in == OFS_ENABLE);
  wire                   sel_sense_h  = (avs_address_in == OFS_SENSE_H);
  wire                   sel_sense_l  = (avs_address_in == OFS_SENSE_L);
  wire                   sel_flags    = (avs_address_in == OFS_FLAGS);
  wire [15:0]            wr_word      = avs_writedata_in[15:0];
  wire [1:0]             wr_be        = avs_byteenable_in[1:0];

  // next register values, unused bits forced to zero
  wire [15:0]            next_enable  = merge16(irq_enable_reg, wr_word, wr_be, MASK_ENABLE);
  wire [15:0]            next_sense_h = merge16(sense_control_high, wr_word, wr_be, MASK_SENSE_H);
  wire [15:0]            next_sense_l = merge16(sense_control_low, wr_word, wr_be, MASK_SENSE_L);

  // sense fields of all pins, pin i at bits 2i+1:2i
  wire [SENSE_W-1:0]     sense_all    = {sense_control_high[7:0], sense_control_low};
  wire [SENSE_W-1:0]     sense_new    = {next_sense_h[7:0], next_sense_l};

  // a rewrite that changes a field disturbs that pin's detector
  wire                   sense_wr     = wr_commit & (sel_sense_h | sel_sense_l);
  wire [SENSE_W-1:0]     sense_wr_val = sel_sense_h ? {next_sense_h[7:0], sense_control_low}
                                                    : {sense_control_high[7:0], next_sense_l};
  wire [NUM_PINS-1:0]    sense_glitch = sense_wr ? field_change(sense_all, sense_wr_val) : '0;

  // flag clear by writing 0 over a 1, set wins over clear
  wire [15:0]            flag_lane    = {{8{wr_be[1]}}, {8{wr_be[0]}}};
  wire [NUM_PINS-1:0]    flag_clear   = (wr_commit & sel_flags) ? (~wr_word[11:0] & flag_lane[11:0])
                                                                : '0;
  wire [NUM_PINS-1:0]    flag_set     = sense_hit | sense_glitch;
  wire [NUM_PINS-1:0]    next_flags   = (request_flag_reg & ~flag_clear) | flag_set;

  // request forwarded only for enabled pins
  wire [NUM_PINS-1:0]    next_request = next_flags & irq_enable_reg[11:0];

  // read multiplexer, unused and unmapped bits read zero
  wire [15:0]            rd_word      = sel_enable  ? (irq_enable_reg & MASK_ENABLE)
                                      : sel_sense_h ? (sense_control_high & MASK_SENSE_H)
                                      : sel_sense_l ? sense_control_low
                                      : sel_flags   ? {4'h0, request_flag_reg}
                                      : 16'h0000;

  // ****************************************
  // pin synchronisation and detection
  // ****************************************

  // two flops before any logic sees a pin
  eis_pin_sync u_sync
  (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (ext_request_pin_n_in),
    .sync_out (pin_sync)
  );

  // level or edge hit per pin from its sense field
  eis_sense u_sense
  (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .level_in (pin_sync),
    .sense_in (sense_all),
    .hit_out  (sense_hit)
  );

  // ****************************************
  // bus handshake
  // ****************************************

  // waitrequest drops for one cycle after a request is seen
  always_comb
  begin
    case (bus_state)
      EIS_BUS_WAIT: next_bus_state = bus_take ? EIS_BUS_ACK : EIS_BUS_WAIT;
      EIS_BUS_ACK:  next_bus_state = EIS_BUS_WAIT;
      default:      next_bus_state = EIS_BUS_WAIT;
    endcase
  end

  // bus state and read data
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      bus_state        <= EIS_BUS_WAIT;
      avs_readdata_out <= '0;
    end
    else
    begin
      bus_state <= next_bus_state;
      if (bus_take & avs_read_in)
        avs_readdata_out <= {16'h0000, rd_word};
    end
  end

  assign avs_waitrequest_out = bus_state;   // state code is the waitrequest level

  // ****************************************
  // control registers
  // ****************************************

  // enable and sense registers, written at the edge that ends the one-cycle waitrequest low
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      irq_enable_reg     <= RST_ENABLE;
      sense_control_high <= RST_SENSE;
      sense_control_low  <= RST_SENSE;
    end
    else if (wr_commit)
    begin
      if (sel_enable)
        irq_enable_reg     <= next_enable;
      if (sel_sense_h)
        sense_control_high <= next_sense_h;
      if (sel_sense_l)
        sense_control_low  <= next_sense_l;
    end
  end

  // ****************************************
  // request flags and outputs
  // ****************************************

  // flags, forwarded requests and flag copy
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      request_flag_reg <= RST_FLAGS;
      irq_request_out  <= RST_FLAGS;
      request_flag_out <= RST_FLAGS;
    end
    else
    begin
      request_flag_reg <= next_flags;
      irq_request_out  <= next_request;
      request_flag_out <= next_flags;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // previous synchronised level, kept apart from the detector so the checks stand on their own
  logic [NUM_PINS-1:0]   chk_prev_pin;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      chk_prev_pin <= RST_PIN_IDLE;
    else
      chk_prev_pin <= pin_sync;
  end

  // expected hits per sense code
  wire [NUM_PINS-1:0]    low_hit  = ~pin_sync & mode_mask(sense_all, SENSE_LOW);
  wire [NUM_PINS-1:0]    fall_hit = chk_prev_pin & ~pin_sync & mode_mask(sense_all, SENSE_FALL);
  wire [NUM_PINS-1:0]    rise_hit = ~chk_prev_pin & pin_sync & mode_mask(sense_all, SENSE_RISE);
  wire [NUM_PINS-1:0]    both_hit = (chk_prev_pin ^ pin_sync) & mode_mask(sense_all, SENSE_BOTH);

  property p_req_gated;
    1 |=> (irq_request_out & ~$past(irq_enable_reg[11:0])) == '0;
  endproperty
  a_req_gated: assert property (p_req_gated) else $error("request out on a disabled pin");

  property p_enable_reset;
    $fell(reset_in) |-> irq_enable_reg == 16'h0000 && sense_all == '0;
  endproperty
  a_enable_reset: assert property (disable iff (1'b0) p_enable_reset)
    else $error("enables or sense fields not cleared by reset");

  property p_reserved_read;
    bus_take & avs_read_in & (sel_enable | sel_sense_h)
      |=> !avs_waitrequest_out && avs_readdata_out[31:12] == '0
          && (!$past(sel_sense_h) || avs_readdata_out[11:8] == 4'h0);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bits read nonzero");

  property p_low_level;
    1 |=> (request_flag_reg & $past(low_hit)) == $past(low_hit);
  endproperty
  a_low_level: assert property (p_low_level) else $error("low level did not set flag");

  property p_fall_edge;
    1 |=> (request_flag_reg & $past(fall_hit)) == $past(fall_hit);
  endproperty
  a_fall_edge: assert property (p_fall_edge) else $error("falling edge did not set flag");

  property p_rise_edge;
    1 |=> (request_flag_reg & $past(rise_hit)) == $past(rise_hit);
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("rising edge did not set flag");

  property p_both_edge;
    1 |=> (request_flag_reg & $past(both_hit)) == $past(both_hit);
  endproperty
  a_both_edge: assert property (p_both_edge) else $error("edge in both mode did not set flag");

  property p_sense_glitch;
    sense_glitch != '0 |=> (request_flag_reg & $past(sense_glitch)) == $past(sense_glitch);
  endproperty
  a_sense_glitch: assert property (p_sense_glitch) else $error("field rewrite did not set flag");

  property p_flag_hold;
    flag_clear == '0 |=> (request_flag_reg & $past(request_flag_reg)) == $past(request_flag_reg);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost without a clear");

  property p_bus_answer;
    bus_req && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("waitrequest not low for exactly one cycle");

  // waitrequest stays high while nobody asks
  property p_idle_wait;
    !bus_req && avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("waitrequest dropped with no request");

  // read data hold until the next read is taken
  property p_read_hold;
    !(bus_take && avs_read_in) |=> $stable(avs_readdata_out);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved without a read");

  // enables move only at a committed write to their own register
  property p_enable_hold;
    !(wr_commit && sel_enable) |=> irq_enable_reg == $past(irq_enable_reg);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable register changed without a write");

  // sense fields move only at a committed write to a sense register
  property p_sense_hold;
    !(wr_commit && (sel_sense_h || sel_sense_l)) |=> sense_all == $past(sense_all);
  endproperty
  a_sense_hold: assert property (p_sense_hold) else $error("sense field changed without a write");

  // unused register bits never hold a one
  property p_reserved_zero;
    1 |-> irq_enable_reg[15:12] == 4'h0 && sense_control_high[15:8] == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved register bits set");

  // every enabled flag is forwarded one edge after the enable is seen
  property p_req_forward;
    1 |=> irq_request_out == (request_flag_reg & $past(irq_enable_reg[11:0]));
  endproperty
  a_req_forward: assert property (p_req_forward) else $error("enabled flag not forwarded");

  // a full-width flag write clears every zero bit that no hit sets again
  property p_flag_clear;
    wr_commit && sel_flags && wr_be == 2'h3
      |=> (request_flag_reg & ~$past(wr_word[11:0]) & ~$past(sense_hit)) == '0;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by a zero write");

  // pins reach the detector exactly two edges after they are sampled
  property p_sync_delay;
    !$past(reset_in) && !$past(reset_in, 2) |-> pin_sync == $past(ext_request_pin_n_in, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("pin level not seen two edges later");

endmodule : eis_top

/* File: testbench/eis_pin_model.sv */
// board-side driver of the twelve external request pins
`timescale 1ns/1ps
module eis_pin_model
(
  input  wire logic                         clk_in,
  input  wire logic [eis_pkg::NUM_PINS-1:0] target_in,
  output logic      [eis_pkg::NUM_PINS-1:0] pin_n_out
);
  import eis_pkg::*;

  // ****************************************
  // pin drive
  // ****************************************
  // pull-ups hold the pins high until the board drives them
  initial pin_n_out = RST_PIN_IDLE;

  // levels move only just after an edge and then stay put, so each change is one clean transition
  always @(posedge clk_in)
  begin
    pin_n_out <= target_in;
  end
endmodule : eis_pin_model

/* File: testbench/tb.sv */
// self-checking bench of the external request enable and sense block
`timescale 1ns/1ps
module tb;
  import eis_pkg::*;

  typedef struct packed {logic [3:0] pin; logic [1:0] code; logic from_lvl; logic to_lvl; logic hit;} eis_row_s;

  logic                clk_in            = 1'b0;
  logic                reset_in          = 1'b1;
  logic [ADDR_W-1:0]   avs_address_in    = 6'h00;
  logic                avs_read_in       = 1'b0;
  logic                avs_write_in      = 1'b0;
  logic [DATA_W-1:0]   avs_writedata_in  = 32'h0;
  logic [3:0]          avs_byteenable_in = 4'h0;
  logic [3:0]          lanes             = 4'h3;
  logic [DATA_W-1:0]   avs_readdata_out;
  logic                avs_waitrequest_out;
  logic [NUM_PINS-1:0] target            = RST_PIN_IDLE;
  logic [NUM_PINS-1:0] pin_n;
  logic [NUM_PINS-1:0] irq_request_out;
  logic [NUM_PINS-1:0] request_flag_out;
  logic [15:0]         rd;
  logic [11:0]         want;
  int                  n_errors          = 0;
  int                  n_tests           = 0;
  int                  n_cycles          = 0;
  // ordinary cases: pin, sense code, level before, level after, flag expected
  eis_row_s            rows [10]         = '{'{4'h0, SENSE_LOW, 1'b1, 1'b0, 1'b1},
    '{4'h1, SENSE_FALL, 1'b1, 1'b0, 1'b1}, '{4'h2, SENSE_FALL, 1'b0, 1'b1, 1'b0},
    '{4'h3, SENSE_RISE, 1'b0, 1'b1, 1'b1}, '{4'h4, SENSE_RISE, 1'b1, 1'b0, 1'b0},
    '{4'h5, SENSE_BOTH, 1'b1, 1'b0, 1'b1}, '{4'h9, SENSE_BOTH, 1'b0, 1'b1, 1'b1},
    '{4'ha, SENSE_LOW, 1'b1, 1'b1, 1'b0}, '{4'hb, SENSE_RISE, 1'b0, 1'b1, 1'b1},
    '{4'h8, SENSE_FALL, 1'b1, 1'b0, 1'b1}};

  // clock and hang guard
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    n_cycles++;
    if (n_cycles == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  eis_top uut (.clk_in(clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .ext_request_pin_n_in(pin_n),
    .irq_request_out(irq_request_out), .request_flag_out(request_flag_out));

  eis_pin_model board (.clk_in(clk_in), .target_in(target), .pin_n_out(pin_n));

  // ****************************************
  // tasks
  // ****************************************
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one bus cycle held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] addr, input logic [15:0] data);
    @(posedge clk_in);
    avs_write_in      <= wr;
    avs_read_in       <= ~wr;
    avs_address_in    <= addr;
    avs_writedata_in  <= {16'h0000, data};
    avs_byteenable_in <= lanes;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out[15:0];
    avs_write_in      <= 1'b0;
    avs_read_in       <= 1'b0;
  endtask : bus

  task automatic reg_check(input string what, input logic [5:0] addr, input logic [15:0] exp);
    bus(1'b0, addr, 16'h0000);
    check(what, exp, rd);
  endtask : reg_check

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask : ticks

  task automatic set_sense(input int pin, input logic [1:0] code);
    logic [23:0] f;
    f = 24'h000000;
    f[2*pin +: 2] = code;
    bus(1'b1, OFS_SENSE_L, f[15:0]);
    bus(1'b1, OFS_SENSE_H, {8'h00, f[23:16]});
    bus(1'b1, OFS_FLAGS, 16'h0000);
  endtask : set_sense

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    // reset values and quiet outputs
    reg_check("enable", OFS_ENABLE, RST_ENABLE);
    reg_check("sense high", OFS_SENSE_H, RST_SENSE);
    reg_check("sense low", OFS_SENSE_L, RST_SENSE);
    ticks(0);
    check("flags out", 16'h0000, {4'h0, request_flag_out});
    check("irq out", 16'h0000, {4'h0, irq_request_out});
    $display("reset test done");
    // unused bits read zero, unmapped address reads zero
    bus(1'b1, OFS_ENABLE, 16'hffff);
    reg_check("enable mask", OFS_ENABLE, MASK_ENABLE);
    bus(1'b1, OFS_ENABLE, 16'h0000);
    lanes = 4'h2;
    bus(1'b1, OFS_ENABLE, 16'hffff);
    lanes = 4'h3;
    reg_check("enable high lane", OFS_ENABLE, 16'h0f00);
    bus(1'b1, OFS_ENABLE, 16'h0000);
    bus(1'b1, OFS_SENSE_H, 16'hffff);
    reg_check("sense high mask", OFS_SENSE_H, MASK_SENSE_H);
    bus(1'b1, OFS_SENSE_L, 16'hffff);
    reg_check("sense low mask", OFS_SENSE_L, MASK_SENSE_L);
    reg_check("unmapped", 6'h10, 16'h0000);
    set_sense(0, SENSE_LOW);
    $display("mask test done");
    // table of sense codes across pins of both sense registers
    foreach (rows[i])
    begin
      target[rows[i].pin] <= rows[i].from_lvl;
      ticks(4);
      set_sense(rows[i].pin, rows[i].code);
      ticks(4);
      bus(1'b1, OFS_FLAGS, 16'h0000);
      target[rows[i].pin] <= rows[i].to_lvl;
      ticks(5);
      want = 12'h000;
      want[rows[i].pin] = rows[i].hit;
      check("flags out", {4'h0, want}, {4'h0, request_flag_out});
      reg_check("flag register", OFS_FLAGS, {4'h0, want});
      ticks(0);
      check("irq out", 16'h0000, {4'h0, irq_request_out});
      target[rows[i].pin] <= 1'b1;
      ticks(4);
      $display("row %0d done", i);
    end
    // enable gates the request, flag stays recorded
    set_sense(6, SENSE_FALL);
    target[6] <= 1'b0;
    ticks(5);
    check("flags out", 16'h0040, {4'h0, request_flag_out});
    check("irq disabled", 16'h0000, {4'h0, irq_request_out});
    bus(1'b1, OFS_ENABLE, 16'h0040);
    ticks(2);
    check("irq enabled", 16'h0040, {4'h0, irq_request_out});
    bus(1'b1, OFS_ENABLE, 16'h0000);
    ticks(2);
    check("irq off again", 16'h0000, {4'h0, irq_request_out});
    target[6] <= 1'b1;
    $display("enable test done");
    // exact latency and one count per transition
    set_sense(7, SENSE_BOTH);
    ticks(4);
    bus(1'b1, OFS_FLAGS, 16'h0000);
    @(posedge clk_in);
    target[7] <= 1'b0;
    ticks(3);
    check("flag early", 16'h0000, {4'h0, request_flag_out});
    ticks(1);
    check("flag on time", 16'h0080, {4'h0, request_flag_out});
    bus(1'b1, OFS_FLAGS, 16'h0000);
    ticks(8);
    check("flag once", 16'h0000, {4'h0, request_flag_out});
    target[7] <= 1'b1;
    ticks(5);
    check("flag rise", 16'h0080, {4'h0, request_flag_out});
    $display("latency test done");
    // sense rewrite on an enabled pin
    bus(1'b1, OFS_FLAGS, 16'h0000);
    bus(1'b1, OFS_ENABLE, 16'h0001);
    bus(1'b1, OFS_SENSE_L, 16'h0001);
    ticks(2);
    check("rewrite flags", 16'h0081, {4'h0, request_flag_out});
    check("rewrite irq", 16'h0001, {4'h0, irq_request_out});
    $display("rewrite test done");
    // second reset in mid-run, raised at a rising edge
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    reg_check("enable again", OFS_ENABLE, RST_ENABLE);
    reg_check("sense again", OFS_SENSE_L, RST_SENSE);
    ticks(0);
    check("flags again", 16'h0000, {4'h0, request_flag_out});
    $display("second reset test done");
    give_verdict();
  end
endmodule : tb
